// ---- bsac_bar_dec.sv ----
// sync barrier decoder with full-barrier alias
`timescale 1ns/1ns
module bsac_bar_dec (
    input wire logic [31:0] instr,
    input wire logic compact,
    input wire logic [1:0] level,
    output logic hit,
    output logic [3:0] opt,
    output bsac_pkg::bsac_bar_s bar
);
    function automatic bsac_pkg::bsac_bar_s opt_map(input logic [3:0] o, input logic hyp);
        bsac_pkg::bsac_bar_s b;
        b = '{full: 1'b0, all_ctx: 1'b0, domain: bsac_pkg::DOM_SYS, types: bsac_pkg::TYP_ALL};
        unique case (o)
            bsac_pkg::OPT_OSHLD: b.domain = bsac_pkg::DOM_OSH;
            bsac_pkg::OPT_OSHST: b.domain = bsac_pkg::DOM_OSH;
            bsac_pkg::OPT_OSH: b.domain = bsac_pkg::DOM_OSH;
            bsac_pkg::OPT_NSHLD: b.domain = bsac_pkg::DOM_NSH;
            bsac_pkg::OPT_NSHST: b.domain = bsac_pkg::DOM_NSH;
            bsac_pkg::OPT_NSH: b.domain = bsac_pkg::DOM_NSH;
            bsac_pkg::OPT_ISHLD: b.domain = bsac_pkg::DOM_ISH;
            bsac_pkg::OPT_ISHST: b.domain = bsac_pkg::DOM_ISH;
            bsac_pkg::OPT_ISH: b.domain = bsac_pkg::DOM_ISH;
            default: b.domain = bsac_pkg::DOM_SYS;
        endcase
        if (o == bsac_pkg::OPT_OSHLD || o == bsac_pkg::OPT_NSHLD || o == bsac_pkg::OPT_ISHLD
            || o == bsac_pkg::OPT_LD)
        begin
            b.types = bsac_pkg::TYP_RD;
        end
        if (o == bsac_pkg::OPT_OSHST || o == bsac_pkg::OPT_NSHST || o == bsac_pkg::OPT_ISHST
            || o == bsac_pkg::OPT_ST)
        begin
            b.types = bsac_pkg::TYP_WR;
        end
        // only hyp gets the stronger barrier; below it the default is already full system
        b.full = (o == bsac_pkg::OPT_FULL_BAR) && hyp;
        b.all_ctx = b.full;
        return b;
    endfunction

    always_comb
    begin
        // should-be-one/zero bits are not checked
        if (compact)
        begin
            hit = instr[31:20] == bsac_pkg::CMPT_HI && instr[15:14] == bsac_pkg::CMPT_MID
                && !instr[12] && instr[7:4] == bsac_pkg::BAR_NIB;
        end
        else
        begin
            hit = instr[31:20] == bsac_pkg::WIDE_HI && instr[7:4] == bsac_pkg::BAR_NIB;
        end
        opt = instr[3:0];
        bar = opt_map(instr[3:0], level == bsac_pkg::LVL_HYP);
    end
endmodule // bsac_bar_dec

// ---- bsac_mem_model.sv ----
// memory system model: earlier accesses drain over a set number of cycles
`timescale 1ns/1ns
module bsac_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [7:0] len,
    output logic mem_idle
);
    logic [7:0] cnt_ff;
    // load marks accesses still in flight at the barrier's take edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_ff <= 8'h00;
        else if (load)
            cnt_ff <= len;
        else if (cnt_ff != 8'h00)
            cnt_ff <= cnt_ff - 8'h01;
    end
    assign mem_idle = (cnt_ff == 8'h00);
endmodule // bsac_mem_model

// ---- bsac_pkg.sv ----
// shared constants and types for the barrier decoder and register access checker
// Functional notes
// - full barrier holds later instructions until all earlier memory accesses complete
// - full barrier at hyp level orders accesses of every level and machine tag
// - full barrier below hyp level acts as sync barrier, full system, reads and writes
// - full barrier is sync barrier with option 12, wide and compact forms
// - wide form is unconditional; no condition check applied
// - unlisted register encodings are unassigned
// - process id legacy reads zero, ignores writes at hyp/kernel; none at user
// - counter frequency read/write at hyp, read-only at kernel and user
// - physical count read-only at hyp, configurable at kernel and user; reads gated by counter read bit, writes always refused
// - debug tx internal write-only, debug rx internal read-only at all levels
// - debug link return and saved status read/write at all levels
// - os lock access write-only at hyp and kernel, none at user
// - float status control is configurable at all levels
// - hyp config read/write at hyp, none below
// - option twelve is full barrier only at hyp; else full system sync barrier
// - reserved or unimplemented options act as full system sync barrier
package bsac_pkg;
    localparam logic [1:0] LVL_USER = 2'h0;
    localparam logic [1:0] LVL_KERN = 2'h1;
    localparam logic [1:0] LVL_HYP = 2'h2;
    localparam logic [11:0] WIDE_HI = 12'hF57;
    localparam logic [11:0] CMPT_HI = 12'hF3B;
    localparam logic [1:0] CMPT_MID = 2'h2;
    localparam logic [3:0] BAR_NIB = 4'h4;
    localparam logic [3:0] OPT_FULL_BAR = 4'hC;
    localparam logic [3:0] OPT_LD = 4'hD;
    localparam logic [3:0] OPT_ST = 4'hE;
    localparam logic [3:0] OPT_ISH = 4'hB;
    localparam logic [3:0] OPT_ISHST = 4'hA;
    localparam logic [3:0] OPT_ISHLD = 4'h9;
    localparam logic [3:0] OPT_NSH = 4'h7;
    localparam logic [3:0] OPT_NSHST = 4'h6;
    localparam logic [3:0] OPT_NSHLD = 4'h5;
    localparam logic [3:0] OPT_OSH = 4'h3;
    localparam logic [3:0] OPT_OSHST = 4'h2;
    localparam logic [3:0] OPT_OSHLD = 4'h1;
    localparam logic [5:0] SR_PROC_ID_LEGACY = 6'h01;
    localparam logic [5:0] SR_CNT_FREQ = 6'h02;
    localparam logic [5:0] SR_PHYS_COUNT = 6'h03;
    localparam logic [5:0] SR_DBG_TX_INT = 6'h04;
    localparam logic [5:0] SR_DBG_RX_INT = 6'h05;
    localparam logic [5:0] SR_HYP_RGN_INFO = 6'h06;
    localparam logic [5:0] SR_HYP_RGN_SEL = 6'h07;
    localparam logic [5:0] SR_HYP_RGN_BASE = 6'h08;
    localparam logic [5:0] SR_HYP_RGN_BASE_N = 6'h09;
    localparam logic [5:0] SR_HYP_RGN_LIM = 6'h0A;
    localparam logic [5:0] SR_HYP_RGN_LIM_N = 6'h0B;
    localparam logic [5:0] SR_HYP_RGN_EN = 6'h0C;
    localparam logic [5:0] SR_DBG_LINK_RET = 6'h0D;
    localparam logic [5:0] SR_DBG_SAVED_ST = 6'h0E;
    localparam logic [5:0] SR_OS_LOCK_ACC = 6'h0F;
    localparam logic [5:0] SR_FLOAT_STAT = 6'h10;
    localparam logic [5:0] SR_HYP_CONFIG = 6'h11;
    localparam logic [11:0] ADDR_CFG = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_FULL_CNT = 12'h008;
    localparam logic [11:0] ADDR_UNDEF_CNT = 12'h00C;
    localparam int CFG_CNT_RD_BIT = 0;
    localparam int CFG_CNT_WR_BIT = 1;
    localparam int CFG_FP_BIT = 2;
    localparam logic [2:0] CFG_RESET = 3'h0;
    localparam int STAT_STALL_BIT = 0;
    localparam int STAT_LAST_FULL_BIT = 1;
    localparam int STAT_LAST_UNDEF_BIT = 2;
    typedef enum logic [1:0] {DOM_NSH, DOM_ISH, DOM_OSH, DOM_SYS} bsac_domain_e;
    typedef enum logic [1:0] {TYP_RD, TYP_WR, TYP_ALL} bsac_types_e;
    typedef enum logic [2:0] {ACC_RW, ACC_RO, ACC_WO, ACC_ZERO, ACC_CFG, ACC_NONE} bsac_acc_e;
    typedef struct packed {
        logic full;
        logic all_ctx;
        bsac_domain_e domain;
        bsac_types_e types;
    } bsac_bar_s;
    typedef struct packed {
        logic [5:0] id;
        logic wr;
    } bsac_sreq_s;
    typedef struct packed {
        logic ok;
        logic undef;
        logic rdzero;
    } bsac_sres_s;
endpackage

// ---- bsac_sysreg_chk.sv ----
// system register access permission checker
`timescale 1ns/1ns
module bsac_sysreg_chk (
    input bsac_pkg::bsac_sreq_s req,
    input wire logic [1:0] level,
    input wire logic [2:0] cfg,
    output bsac_pkg::bsac_sres_s res
);
    function automatic bsac_pkg::bsac_acc_e perm(input logic [5:0] id, input logic [1:0] lv);
        logic hyp;
        logic kern;
        bsac_pkg::bsac_acc_e a;
        hyp = lv == bsac_pkg::LVL_HYP;
        kern = lv == bsac_pkg::LVL_KERN;
        a = bsac_pkg::ACC_NONE;
        unique case (id)
            bsac_pkg::SR_PROC_ID_LEGACY: a = (hyp || kern) ? bsac_pkg::ACC_ZERO
                : bsac_pkg::ACC_NONE;
            bsac_pkg::SR_CNT_FREQ: a = hyp ? bsac_pkg::ACC_RW : bsac_pkg::ACC_RO;
            bsac_pkg::SR_PHYS_COUNT: a = hyp ? bsac_pkg::ACC_RO : bsac_pkg::ACC_CFG;
            bsac_pkg::SR_DBG_TX_INT: a = bsac_pkg::ACC_WO;
            bsac_pkg::SR_DBG_RX_INT: a = bsac_pkg::ACC_RO;
            bsac_pkg::SR_HYP_RGN_INFO: a = hyp ? bsac_pkg::ACC_RO : bsac_pkg::ACC_NONE;
            bsac_pkg::SR_HYP_RGN_SEL, bsac_pkg::SR_HYP_RGN_BASE, bsac_pkg::SR_HYP_RGN_BASE_N,
            bsac_pkg::SR_HYP_RGN_LIM, bsac_pkg::SR_HYP_RGN_LIM_N, bsac_pkg::SR_HYP_RGN_EN:
                a = hyp ? bsac_pkg::ACC_RW : bsac_pkg::ACC_NONE;
            bsac_pkg::SR_DBG_LINK_RET, bsac_pkg::SR_DBG_SAVED_ST: a = bsac_pkg::ACC_RW;
            bsac_pkg::SR_OS_LOCK_ACC: a = (hyp || kern) ? bsac_pkg::ACC_WO
                : bsac_pkg::ACC_NONE;
            bsac_pkg::SR_FLOAT_STAT: a = bsac_pkg::ACC_CFG;
            bsac_pkg::SR_HYP_CONFIG: a = hyp ? bsac_pkg::ACC_RW : bsac_pkg::ACC_NONE;
            default: a = bsac_pkg::ACC_NONE;
        endcase
        return a;
    endfunction

    bsac_pkg::bsac_acc_e acc;
    logic cfg_ok;

    always_comb
    begin
        acc = perm(req.id, level);
        // configurable entries resolve through the counter read and float enable bits; physical count writes are always refused
        if (req.id == bsac_pkg::SR_FLOAT_STAT)
        begin
            cfg_ok = cfg[bsac_pkg::CFG_FP_BIT];
        end
        else
        begin
            cfg_ok = req.wr ? 1'b0 : cfg[bsac_pkg::CFG_CNT_RD_BIT];
        end
        res.rdzero = acc == bsac_pkg::ACC_ZERO && !req.wr;
        unique case (acc)
            bsac_pkg::ACC_RW: res.ok = 1'b1;
            bsac_pkg::ACC_RO: res.ok = !req.wr;
            bsac_pkg::ACC_WO: res.ok = req.wr;
            bsac_pkg::ACC_ZERO: res.ok = 1'b1;
            bsac_pkg::ACC_CFG: res.ok = cfg_ok;
            default: res.ok = 1'b0;
        endcase
        res.undef = !res.ok;
    end
endmodule // bsac_sysreg_chk

// ---- bsac_top.sv ----
// decode-stage barrier handling and system register access check with apb registers
`timescale 1ns/1ns
module bsac_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic instr_compact,
    input wire logic cond_pass,
    input wire logic [1:0] cur_level,
    output logic instr_ready,
    input wire logic sreq_valid,
    input bsac_pkg::bsac_sreq_s sreq,
    output logic sres_valid,
    output bsac_pkg::bsac_sres_s sres,
    input wire logic mem_idle,
    output logic bar_req,
    output bsac_pkg::bsac_bar_s bar_info,
    output logic stall
);
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [2:0] cfg_ff;
    logic [31:0] full_cnt_ff;
    logic [31:0] undef_cnt_ff;
    logic last_undef_ff;
    logic instr_ready_ff;
    logic bar_req_ff;
    bsac_pkg::bsac_bar_s bar_ff;
    logic stall_ff;
    logic sres_valid_ff;
    bsac_pkg::bsac_sres_s sres_ff;
    logic dec_hit;
    logic [3:0] dec_opt;
    bsac_pkg::bsac_bar_s dec_bar;
    bsac_pkg::bsac_sres_s chk_res;
    logic instr_fire;
    logic bar_fire;
    logic sreq_fire;
    logic setup;
    logic nxt_stall;

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign instr_ready = instr_ready_ff;
    assign bar_req = bar_req_ff;
    assign bar_info = bar_ff;
    assign stall = stall_ff;
    assign sres_valid = sres_valid_ff;
    assign sres = sres_ff;

    bsac_bar_dec u_bar_dec (
        .instr(instr_word),
        .compact(instr_compact),
        .level(cur_level),
        .hit(dec_hit),
        .opt(dec_opt),
        .bar(dec_bar)
    );

    bsac_sysreg_chk u_sysreg_chk (
        .req(sreq),
        .level(cur_level),
        .cfg(cfg_ff),
        .res(chk_res)
    );

    assign setup = psel && !penable;
    assign instr_fire = instr_valid && instr_ready_ff;
    // compact form may sit in a conditional block; wide form never checks the condition
    assign bar_fire = instr_fire && dec_hit && (!instr_compact || cond_pass);
    assign sreq_fire = sreq_valid && instr_ready_ff;

    // apb slave: zero wait states, data and status prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end
        else
        begin
            pready_ff <= setup;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            if (setup)
            begin
                unique case (paddr)
                    bsac_pkg::ADDR_CFG: prdata_ff <= {29'h00000000, cfg_ff};
                    bsac_pkg::ADDR_STATUS: prdata_ff <= {29'h00000000, last_undef_ff,
                        bar_ff.full, stall_ff};
                    bsac_pkg::ADDR_FULL_CNT: prdata_ff <= full_cnt_ff;
                    bsac_pkg::ADDR_UNDEF_CNT: prdata_ff <= undef_cnt_ff;
                    default: pslverr_ff <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_ff <= bsac_pkg::CFG_RESET;
        end
        else if (psel && penable && pready_ff && pwrite && paddr == bsac_pkg::ADDR_CFG)
        begin
            cfg_ff <= pwdata[2:0];
        end
    end

    // barrier issue and stall towards fetch
    always_comb
    begin
        nxt_stall = stall_ff;
        if (bar_fire)
        begin
            nxt_stall = 1'b1;
        end
        else if (mem_idle)
        begin
            nxt_stall = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stall_ff <= 1'b0;
            instr_ready_ff <= 1'b0;
            bar_req_ff <= 1'b0;
            bar_ff <= '{full: 1'b0, all_ctx: 1'b0, domain: bsac_pkg::DOM_SYS,
                types: bsac_pkg::TYP_ALL};
        end
        else
        begin
            stall_ff <= nxt_stall;
            // ready drops the cycle after a barrier is taken, so nothing later slips past
            instr_ready_ff <= !nxt_stall;
            bar_req_ff <= bar_fire;
            if (bar_fire)
            begin
                bar_ff <= dec_bar;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            full_cnt_ff <= 32'h00000000;
        end
        else if (bar_fire && dec_bar.full)
        begin
            full_cnt_ff <= full_cnt_ff + 32'h00000001;
        end
    end

    // register access result, one cycle after the request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sres_valid_ff <= 1'b0;
            sres_ff <= '{ok: 1'b0, undef: 1'b0, rdzero: 1'b0};
            last_undef_ff <= 1'b0;
            undef_cnt_ff <= 32'h00000000;
        end
        else
        begin
            sres_valid_ff <= sreq_fire;
            if (sreq_fire)
            begin
                sres_ff <= chk_res;
                last_undef_ff <= chk_res.undef;
                if (chk_res.undef)
                begin
                    undef_cnt_ff <= undef_cnt_ff + 32'h00000001;
                end
            end
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_stall_hold: assert property (stall_ff && !mem_idle && !bar_fire
        |=> stall_ff && !instr_ready_ff)
        else $error("stall released before memory idle");
    chk_hyp_full: assert property (bar_fire && dec_opt == 4'hC && cur_level == bsac_pkg::LVL_HYP
        |=> bar_req_ff && bar_ff.full && bar_ff.all_ctx)
        else $error("hyp full barrier not issued");
    chk_low_sys: assert property (bar_fire && dec_opt == 4'hC && cur_level != bsac_pkg::LVL_HYP
        |=> !bar_ff.full && bar_ff.domain == bsac_pkg::DOM_SYS
        && bar_ff.types == bsac_pkg::TYP_ALL)
        else $error("option twelve below hyp not full system");
    // ready is low in the issue cycle; with memory already idle it returns one cycle later
    chk_cmpt_decode: assert property (instr_fire && instr_compact && cond_pass
        && instr_word[31:20] == 12'hF3B && instr_word[15:14] == 2'h2 && !instr_word[12]
        && instr_word[7:4] == 4'h4 |=> bar_req_ff && !instr_ready_ff)
        else $error("compact barrier not decoded");
    chk_wide_uncond: assert property (instr_fire && !instr_compact && !cond_pass
        && instr_word[31:20] == 12'hF57 && instr_word[7:4] == 4'h4 |=> bar_req_ff)
        else $error("wide barrier wrongly conditional");
    chk_reserved_opt: assert property (bar_fire && dec_opt == 4'h0
        |=> bar_ff.domain == bsac_pkg::DOM_SYS && bar_ff.types == bsac_pkg::TYP_ALL)
        else $error("reserved option not full system");
    chk_unassigned: assert property (sreq_fire && sreq.id == 6'h3F
        |=> sres_valid_ff && sres_ff.undef && undef_cnt_ff == $past(undef_cnt_ff) + 32'h1)
        else $error("unassigned encoding accepted");
    chk_legacy_zero: assert property (sreq_fire && sreq.id == 6'h01 && !sreq.wr
        && cur_level == bsac_pkg::LVL_KERN |=> sres_ff.ok && sres_ff.rdzero)
        else $error("legacy id not read as zero");
    chk_freq_user: assert property (sreq_fire && sreq.id == 6'h02 && sreq.wr
        && cur_level == bsac_pkg::LVL_USER |=> sres_ff.undef)
        else $error("counter frequency writable at user");
    chk_oslock_user: assert property (sreq_fire && sreq.id == 6'h0F
        && cur_level == bsac_pkg::LVL_USER |=> sres_ff.undef && !sres_ff.ok)
        else $error("os lock reachable at user");
    chk_hcfg_kern: assert property (sreq_fire && sreq.id == 6'h11
        && cur_level == bsac_pkg::LVL_KERN |=> sres_ff.undef)
        else $error("hyp config reachable below hyp");

    cov_hyp_full: cover property (bar_fire && dec_bar.full ##[1:20] mem_idle);
    cov_cfg_float: cover property (sreq_fire && sreq.id == 6'h10 && chk_res.ok);
    cov_apb_err: cover property (pready_ff && pslverr_ff);
endmodule // bsac_top

// ---- tb_bsac_top.sv ----
// self-checking bench for barrier decode and register access check
`timescale 1ns/1ns
`define CHK(nm, e, g) \
    begin \
        tests_run++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("Error %s expected %h seen %h", nm, e, g); \
        end \
    end
module tb_bsac_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, instr_word = 32'h0;
    logic pready, pslverr, instr_ready, sres_valid, mem_idle, bar_req, stall, err;
    logic instr_valid = 1'b0;
    logic instr_compact = 1'b0;
    logic cond_pass = 1'b0;
    logic sreq_valid = 1'b0;
    logic mem_load = 1'b0;
    logic [1:0] cur_level = 2'h0;
    logic [7:0] mem_len = 8'h00;
    logic [31:0] rd;
    bsac_pkg::bsac_sreq_s sreq = '0;
    bsac_pkg::bsac_sres_s sres;
    bsac_pkg::bsac_bar_s bar_info;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int n_full = 0;
    int n_undef = 0;
    logic last_undef = 1'b0;
    bsac_top i_bsac_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_compact(instr_compact), .cond_pass(cond_pass), .cur_level(cur_level),
        .instr_ready(instr_ready), .sreq_valid(sreq_valid), .sreq(sreq),
        .sres_valid(sres_valid), .sres(sres), .mem_idle(mem_idle), .bar_req(bar_req),
        .bar_info(bar_info), .stall(stall));
    bsac_mem_model i_bsac_mem_model (.pclk(pclk), .presetn(presetn), .load(mem_load),
        .len(mem_len), .mem_idle(mem_idle));
    always #10 pclk = ~pclk;
    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard: far above the few thousand cycles the sequence needs
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            summarize();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait bound here: only the hang guard ends a missing answer
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] wide(input logic [3:0] o);
        return {bsac_pkg::WIDE_HI, 8'hFF, 4'h0, bsac_pkg::BAR_NIB, o};
    endfunction
    function automatic logic [31:0] cmpt(input logic [3:0] o);
        return {bsac_pkg::CMPT_HI, 4'hF, bsac_pkg::CMPT_MID, 2'h0, 4'hF, bsac_pkg::BAR_NIB, o};
    endfunction
    function automatic bsac_pkg::bsac_bar_s exp_bar(input logic [3:0] o, input logic [1:0] lv);
        bsac_pkg::bsac_bar_s b;
        b.full = (o == 4'hC) && (lv == bsac_pkg::LVL_HYP);
        b.all_ctx = b.full;
        b.domain = bsac_pkg::DOM_SYS;
        b.types = bsac_pkg::TYP_ALL;
        // reserved codes and option twelve fall back to full system, all types
        if (o[1:0] != 2'h0 && o != 4'hF)
        begin
            b.types = bsac_pkg::bsac_types_e'(o[1:0] - 2'h1);
            case (o[3:2])
                2'h0: b.domain = bsac_pkg::DOM_OSH;
                2'h1: b.domain = bsac_pkg::DOM_NSH;
                2'h2: b.domain = bsac_pkg::DOM_ISH;
                default: b.domain = bsac_pkg::DOM_SYS;
            endcase
        end
        return b;
    endfunction
    function automatic bsac_pkg::bsac_sres_s exp_sr(input logic [5:0] id, input logic [1:0] lv,
        input logic w, input logic [2:0] c);
        bsac_pkg::bsac_acc_e a;
        bsac_pkg::bsac_sres_s r;
        logic h, u;
        h = (lv == bsac_pkg::LVL_HYP);
        u = !h && (lv != bsac_pkg::LVL_KERN);
        case (id)
            6'h01: a = u ? bsac_pkg::ACC_NONE : bsac_pkg::ACC_ZERO;
            6'h02: a = h ? bsac_pkg::ACC_RW : bsac_pkg::ACC_RO;
            6'h03: a = h ? bsac_pkg::ACC_RO : bsac_pkg::ACC_CFG;
            6'h04: a = bsac_pkg::ACC_WO;
            6'h05: a = bsac_pkg::ACC_RO;
            6'h06: a = h ? bsac_pkg::ACC_RO : bsac_pkg::ACC_NONE;
            6'h0D, 6'h0E: a = bsac_pkg::ACC_RW;
            6'h0F: a = u ? bsac_pkg::ACC_NONE : bsac_pkg::ACC_WO;
            6'h10: a = bsac_pkg::ACC_CFG;
            6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h11:
                a = h ? bsac_pkg::ACC_RW : bsac_pkg::ACC_NONE;
            default: a = bsac_pkg::ACC_NONE;
        endcase
        r.rdzero = (a == bsac_pkg::ACC_ZERO) && !w;
        case (a)
            bsac_pkg::ACC_RW, bsac_pkg::ACC_ZERO: r.ok = 1'b1;
            bsac_pkg::ACC_RO: r.ok = !w;
            bsac_pkg::ACC_WO: r.ok = w;
            bsac_pkg::ACC_CFG: r.ok = (id == 6'h10) ? c[2] : (c[0] && !w);
            default: r.ok = 1'b0;
        endcase
        r.undef = !r.ok;
        return r;
    endfunction
    task automatic sr(input logic [5:0] id, input logic [1:0] lv, input logic w,
        input logic [2:0] c);
        bsac_pkg::bsac_sres_s e;
        e = exp_sr(id, lv, w, c);
        n_undef += e.undef;
        last_undef = e.undef;
        @(posedge pclk);
        sreq_valid <= 1'b1;
        sreq <= {id, w};
        cur_level <= lv;
        @(posedge pclk);
        sreq_valid <= 1'b0;
        #1;
        `CHK("sres_valid", 1'b1, sres_valid)
        `CHK("sres", e, sres)
    endtask
    task automatic bar(input logic [31:0] w, input logic cm, input logic cp, input logic [1:0] lv,
        input logic [7:0] n, input logic hit, input bsac_pkg::bsac_bar_s e);
        int k;
        @(posedge pclk);
        instr_valid <= 1'b1;
        instr_word <= w;
        instr_compact <= cm;
        cond_pass <= cp;
        cur_level <= lv;
        mem_load <= 1'b1;
        mem_len <= n;
        @(posedge pclk);
        instr_valid <= 1'b0;
        mem_load <= 1'b0;
        #1;
        `CHK("bar_req", hit, bar_req)
        if (hit)
        begin
            `CHK("bar_info", e, bar_info)
            n_full += e.full;
            k = 0;
            while (stall === 1'b1 && k < 300)
            begin
                `CHK("ready in stall", 1'b0, instr_ready)
                @(posedge pclk);
                #1;
                k++;
            end
            `CHK("stall cycles", n + 8'h01, k[7:0])
        end
    endtask
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        `CHK("ready", 1'b1, instr_ready)
        `CHK("bar_info reset", {2'h0, bsac_pkg::DOM_SYS, bsac_pkg::TYP_ALL}, bar_info)
        apb(1'b0, bsac_pkg::ADDR_CFG, 32'h0);
        `CHK("cfg reset", 32'h0, rd)
        apb(1'b1, 12'h010, 32'h7);
        `CHK("unmapped err", 1'b1, err)
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, bsac_pkg::ADDR_CFG, 32'(c));
            apb(1'b0, bsac_pkg::ADDR_CFG, 32'h0);
            `CHK("cfg", 32'(c), rd)
            for (int i = 0; i < 21; i++)
                for (int l = 0; l < 8; l++)
                    sr((i == 20) ? 6'h3F : i[5:0], l[2:1], l[0], c[2:0]);
        end
        for (int o = 0; o < 16; o++)
            for (int l = 0; l < 4; l++)
                bar(wide(o[3:0]), 1'b0, 1'b0, l[1:0], {6'h0, l[1:0]}, 1'b1,
                    exp_bar(o[3:0], l[1:0]));
        bar(cmpt(4'hC), 1'b1, 1'b1, 2'h2, 8'h05, 1'b1, exp_bar(4'hC, 2'h2));
        bar(cmpt(4'hC), 1'b1, 1'b0, 2'h2, 8'h00, 1'b0, '0);
        bar(cmpt(4'h7), 1'b1, 1'b1, 2'h1, 8'h14, 1'b1, exp_bar(4'h7, 2'h1));
        bar(cmpt(4'h0), 1'b1, 1'b1, 2'h0, 8'h01, 1'b1, exp_bar(4'h0, 2'h0));
        bar(32'h0, 1'b0, 1'b1, 2'h2, 8'h00, 1'b0, '0);
        apb(1'b0, bsac_pkg::ADDR_FULL_CNT, 32'h0);
        `CHK("full count", n_full, rd)
        apb(1'b0, bsac_pkg::ADDR_UNDEF_CNT, 32'h0);
        `CHK("undef count", n_undef, rd)
        apb(1'b0, bsac_pkg::ADDR_STATUS, 32'h0);
        `CHK("status", {29'h0, last_undef, 2'h0}, rd)
        summarize();
    end
endmodule // tb_bsac_top
